/* File: hdl/cbs_shifter.sv */
// Datapath barrel shifter with its sum, product and multiplicand registers.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "cbs_map.svh"

// How it works
// RULE1 - Shifter holds 64 bits; takes 16, 32 or 64 bit operands.
// RULE2 - Narrow operands sit in the lowest 16 or 32 bit positions first.
// RULE3 - Delivered result is the whole 64 bits, the low 32 or only the low 16.
// RULE4 - Right shift drops low bits; top fills with sign or zeros.
// RULE5 - Left shift zero fills low bits; 16-bit top fill follows sign mode.
// RULE6 - 32-bit left shift drops top bits; sign mode has no effect.
// RULE7 - Sign-fill mode 0 fills zeros, mode 1 fills operand sign.
// RULE8 - Operand load shift: memory 0..16, immediate 0..15, or multiplicand count.
// RULE9 - Low store shifts sum left 0..8 then stores the low 16 bits.
// RULE10 - High store is one right shift by sixteen minus count 0..8.
// RULE11 - Sum left shift by 1..16 or T low 4/5 bits; carry gets last out.
// RULE12 - Half left shift by 1..16 or T low 4 bits; carry gets last out.
// RULE13 - Sum right shift logical or arithmetic by mode; carry gets last out.
// RULE14 - Half logical right shift; carry gets the last bit out.
// RULE15 - Half arithmetic right shift sign fills; zero count clears carry.
// RULE16 - Rotate left: bit 31 to carry, old carry to bit 0.
// RULE17 - Rotate right: bit 0 to carry, old carry to bit 31.
// RULE18 - Sum:product pair shifts left, right, arithmetic right, 1..16 or T low 6.
// RULE19 - Normalise and conditional-subtract steps shift the sum by one bit.
// RULE20 - Product to ALU scaled by mode: left, none, or sign right.
// RULE21 - Product low store scales first, then stores low 16 bits.
// RULE22 - Product high store scales, shifts right 16, stores low 16 bits.
// RULE23 - Product and sum registers are 32 bits and take results.
// RULE24 - Product mode 0 shifts left one; modes 2..7 right by mode minus one.
module cbs_shifter
  import cbs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] i_mult_result,
  input  wire logic        i_mult_wr,
  input  wire logic        i_mult_to_sum,
  output logic      [31:0] o_rdata,
  output logic      [63:0] o_shift_out,
  output logic             o_carry,
  output logic             o_done
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Limits a count to the range allowed for its source.
  function automatic logic [6:0] cbs_clamp(input logic [6:0] n, input logic [6:0] lim);
    cbs_clamp = (n > lim) ? lim : n;
  endfunction

  // Scales the product by the product shift mode.
  function automatic logic [31:0] cbs_scale(input logic [31:0] p, input logic [2:0] pm);
    logic [31:0] r;
    r = p;
    if (pm == 3'h0) begin
      r = p << 1;
    end else if (pm != 3'h1) begin
      r = 32'($signed(p) >>> (pm - 3'h1));
    end
    cbs_scale = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  logic [`CBS_CTRL_W-1:0] ctrl;
  logic [15:0]            opnd;
  logic [31:0]            main_sum_reg;
  logic [31:0]            prod;
  logic [31:0]            mcand;
  logic                   carry;
  logic [63:0]            res;
  logic                   done;
  logic [31:0]            rdata;
  cbs_state_t             state;

  logic [`CBS_CTRL_W-1:0] next_ctrl;
  logic [15:0]            next_opnd;
  logic [31:0]            next_main_sum_reg;
  logic [31:0]            next_prod;
  logic [31:0]            next_mcand;
  logic                   next_carry;
  logic [63:0]            next_res;
  logic                   next_done;
  logic [31:0]            next_rdata;
  cbs_state_t             next_state;

  // ----------------------------------------------------------------
  // Count selection
  // ----------------------------------------------------------------

  cbs_op_t    op;
  logic       sign_fill_mode;
  logic [2:0] product_shift_mode;
  logic [6:0] cnt;
  logic [15:0] sum_upper_word;
  logic [15:0] sum_bottom_word;
  logic [15:0] half;

  assign op                 = cbs_op_t'(ctrl[`CBS_F_OP]);
  assign sign_fill_mode     = ctrl[`CBS_F_SXM];
  assign product_shift_mode = ctrl[`CBS_F_PM];
  assign sum_upper_word     = main_sum_reg[31:16];
  assign sum_bottom_word    = main_sum_reg[15:0];
  assign half               = ctrl[`CBS_F_HALF] ? sum_upper_word : sum_bottom_word;

  always_comb begin
    logic [6:0] t4;
    logic [6:0] t5;
    logic [6:0] t6;
    t4 = {3'h0, mcand[3:0]};
    t5 = {2'h0, mcand[4:0]};
    t6 = {1'h0, mcand[5:0]};
    cnt = {1'h0, ctrl[`CBS_F_CNT]};
    case (op)
      CBS_OPD_LEFT: begin
        if (ctrl[`CBS_F_USE_T]) begin
          cnt = t4;  // see RULE8
        end else begin
          cnt = cbs_clamp(cnt, ctrl[`CBS_F_IMM] ? `CBS_LIM_IMM : `CBS_LIM_MEM);  // see RULE8
        end
      end
      CBS_STORE_LO, CBS_STORE_HI: begin
        cnt = cbs_clamp(cnt, `CBS_LIM_STORE);
      end
      CBS_LEFT_SUM: begin
        if (ctrl[`CBS_F_USE_T]) begin
          cnt = ctrl[`CBS_F_T5] ? t5 : t4;  // see RULE11
        end else begin
          cnt = cbs_clamp(cnt, `CBS_LIM_MEM);
        end
      end
      CBS_LEFT_HALF, CBS_SUM_RIGHT, CBS_RIGHT_HALF: begin
        cnt = ctrl[`CBS_F_USE_T] ? t4 : cbs_clamp(cnt, `CBS_LIM_MEM);  // see RULE12
      end
      CBS_ARITH_HALF: begin
        cnt = ctrl[`CBS_F_USE_T] ? t5 : cbs_clamp(cnt, `CBS_LIM_MEM);  // see RULE15
      end
      CBS_WIDE_LEFT, CBS_WIDE_RIGHT, CBS_WIDE_ARITH: begin
        cnt = ctrl[`CBS_F_USE_T] ? t6 : cbs_clamp(cnt, `CBS_LIM_MEM);  // see RULE18
      end
      default: begin
        cnt = {1'h0, ctrl[`CBS_F_CNT]};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Shift datapath and register writes
  // ----------------------------------------------------------------

  always_comb begin
    logic [64:0] wide;
    logic [63:0] pair;
    logic [32:0] diff;
    logic [31:0] scaled;
    logic [16:0] h;
    next_ctrl         = ctrl;
    next_opnd         = opnd;
    next_main_sum_reg = main_sum_reg;
    next_prod         = prod;
    next_mcand        = mcand;
    next_carry        = carry;
    next_res          = res;
    next_done         = 1'b0;
    next_rdata        = `CBS_RST_WORD;
    next_state        = CBS_IDLE;
    wide              = 65'h0;
    pair              = {main_sum_reg, prod};
    diff              = 33'h0;
    scaled            = cbs_scale(prod, product_shift_mode);  // see RULE24
    h                 = 17'h0;

    case (state)
      CBS_EXEC: begin
        next_done = 1'b1;
        case (op)
          CBS_OPD_LEFT: begin
            // The 16-bit operand enters the low lanes and is filled above.
            wide = {1'b0, {48{sign_fill_mode & opnd[15]}}, opnd};  // see RULE2 RULE5 RULE7
            next_res          = wide[63:0] << cnt;  // see RULE1 RULE3
            next_main_sum_reg = next_res[31:0];  // see RULE8
          end
          CBS_STORE_LO: begin
            wide     = {33'h0, main_sum_reg} << cnt;
            next_res = {48'h0, wide[15:0]};  // see RULE9 RULE3
          end
          CBS_STORE_HI: begin
            wide     = {33'h0, main_sum_reg} >> (`CBS_HALF_SPAN - cnt);
            next_res = {48'h0, wide[15:0]};  // see RULE10
          end
          CBS_LEFT_SUM: begin
            wide              = {33'h0, main_sum_reg} << cnt;
            next_main_sum_reg = wide[31:0];  // see RULE6
            next_carry        = (cnt != 7'h0) & wide[32];  // see RULE11
            next_res          = {32'h0, wide[31:0]};
          end
          CBS_LEFT_HALF: begin
            wide       = {49'h0, half} << cnt;
            next_carry = (cnt != 7'h0) & wide[16];  // see RULE12
            h          = wide[16:0];
          end
          CBS_SUM_RIGHT: begin
            wide = {{32{sign_fill_mode & main_sum_reg[31]}}, main_sum_reg, 1'b0};
            wide = 65'($signed(wide) >>> cnt);  // see RULE4 RULE13
            next_main_sum_reg = wide[32:1];
            next_carry        = (cnt != 7'h0) & wide[0];
            next_res          = {32'h0, wide[32:1]};
          end
          CBS_RIGHT_HALF, CBS_ARITH_HALF: begin
            wide = {{48{(op == CBS_ARITH_HALF) & half[15]}}, half, 1'b0};
            wide = 65'($signed(wide) >>> cnt);  // see RULE14 RULE15
            next_carry = (cnt != 7'h0) & wide[0];
            h          = {1'b0, wide[16:1]};
          end
          CBS_ROT_LEFT: begin
            next_carry        = main_sum_reg[31];  // see RULE16
            next_main_sum_reg = {main_sum_reg[30:0], carry};
            next_res          = {32'h0, main_sum_reg[30:0], carry};
          end
          CBS_ROT_RIGHT: begin
            next_carry        = main_sum_reg[0];  // see RULE17
            next_main_sum_reg = {carry, main_sum_reg[31:1]};
            next_res          = {32'h0, carry, main_sum_reg[31:1]};
          end
          CBS_WIDE_LEFT: begin
            pair = pair << cnt;  // see RULE18
          end
          CBS_WIDE_RIGHT: begin
            pair = pair >> cnt;  // see RULE18
          end
          CBS_WIDE_ARITH: begin
            pair = 64'($signed(pair) >>> cnt);  // see RULE18
          end
          CBS_LEAD_STEP: begin
            // Shift only while the two top bits agree and the sum is non-zero.
            if (ctrl[`CBS_F_COND] && (main_sum_reg[31] == main_sum_reg[30]) &&
                (main_sum_reg != 32'h0)) begin
              next_main_sum_reg = {main_sum_reg[30:0], 1'b0};  // see RULE19
            end
            next_res = {32'h0, next_main_sum_reg};
          end
          CBS_CSUB_STEP: begin
            diff = {1'b0, main_sum_reg} - {2'h0, opnd, 15'h0};
            if (!diff[32]) begin
              next_main_sum_reg = {diff[30:0], 1'b1};  // see RULE19
            end else begin
              next_main_sum_reg = {main_sum_reg[30:0], 1'b0};
            end
            next_res = {32'h0, next_main_sum_reg};
          end
          CBS_PROD_ALU: begin
            next_res = {32'h0, scaled};  // see RULE20
          end
          CBS_PSTORE_LO: begin
            next_res = {48'h0, scaled[15:0]};  // see RULE21
          end
          CBS_PSTORE_HI: begin
            next_res = {48'h0, scaled[31:16]};  // see RULE22
          end
          default: begin
            next_done = 1'b0;
          end
        endcase
        if ((op == CBS_LEFT_HALF) || (op == CBS_RIGHT_HALF) || (op == CBS_ARITH_HALF)) begin
          next_res = {48'h0, h[15:0]};
          if (ctrl[`CBS_F_HALF]) begin
            next_main_sum_reg = {h[15:0], sum_bottom_word};
          end else begin
            next_main_sum_reg = {sum_upper_word, h[15:0]};
          end
        end
        if ((op == CBS_WIDE_LEFT) || (op == CBS_WIDE_RIGHT) || (op == CBS_WIDE_ARITH)) begin
          next_main_sum_reg = pair[63:32];
          next_prod         = pair[31:0];
          next_res          = pair;  // see RULE3
        end
      end
      default: begin
        next_state = CBS_IDLE;
      end
    endcase

    // Multiplier results land in one of the two 32-bit registers.
    if (i_mult_wr) begin
      if (i_mult_to_sum) begin
        next_main_sum_reg = i_mult_result;  // see RULE23
      end else begin
        next_prod = i_mult_result;  // see RULE23
      end
    end

    // Software writes win over the datapath in the same cycle.
    if (i_wr) begin
      case (i_addr)
        `CBS_OFS_CTRL: begin
          next_ctrl  = i_wdata[`CBS_CTRL_W-1:0];
          next_state = CBS_EXEC;
        end
        `CBS_OFS_OPND:  next_opnd         = i_wdata[15:0];
        `CBS_OFS_SUM:   next_main_sum_reg = i_wdata;
        `CBS_OFS_PROD:  next_prod         = i_wdata;
        `CBS_OFS_MCAND: next_mcand        = i_wdata;
        `CBS_OFS_STAT:  next_carry        = i_wdata[0];
        default:        next_opnd         = next_opnd;
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        `CBS_OFS_CTRL:   next_rdata = {{(32-`CBS_CTRL_W){1'b0}}, ctrl};
        `CBS_OFS_OPND:   next_rdata = {16'h0, opnd};
        `CBS_OFS_SUM:    next_rdata = main_sum_reg;
        `CBS_OFS_PROD:   next_rdata = prod;
        `CBS_OFS_MCAND:  next_rdata = mcand;
        `CBS_OFS_STAT:   next_rdata = {30'h0, state == CBS_EXEC, carry};
        `CBS_OFS_RES_LO: next_rdata = res[31:0];
        `CBS_OFS_RES_HI: next_rdata = res[63:32];
        default:         next_rdata = `CBS_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl         <= `CBS_RST_CTRL;
      opnd         <= 16'h0;
      main_sum_reg <= `CBS_RST_WORD;
      prod         <= `CBS_RST_WORD;
      mcand        <= `CBS_RST_WORD;
      carry        <= 1'b0;
      res          <= `CBS_RST_RES;
      done         <= 1'b0;
      rdata        <= `CBS_RST_WORD;
      state        <= CBS_IDLE;
    end else begin
      ctrl         <= next_ctrl;
      opnd         <= next_opnd;
      main_sum_reg <= next_main_sum_reg;
      prod         <= next_prod;
      mcand        <= next_mcand;
      carry        <= next_carry;
      res          <= next_res;
      done         <= next_done;
      rdata        <= next_rdata;
      state        <= next_state;
    end
  end

  assign o_rdata     = rdata;
  assign o_shift_out = res;
  assign o_carry     = carry;
  assign o_done      = done;

endmodule

/* File: hdl/cbs_map.svh */
// Register offsets, control field positions, reset values and limits of the shifter.
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

`define CBS_OFS_CTRL     8'h00
`define CBS_OFS_OPND     8'h04
`define CBS_OFS_SUM      8'h08
`define CBS_OFS_PROD     8'h0c
`define CBS_OFS_MCAND    8'h10
`define CBS_OFS_STAT     8'h14
`define CBS_OFS_RES_LO   8'h18
`define CBS_OFS_RES_HI   8'h1c

`define CBS_F_OP         4:0
`define CBS_F_SXM        5
`define CBS_F_PM         8:6
`define CBS_F_CNT        14:9
`define CBS_F_USE_T      15
`define CBS_F_T5         16
`define CBS_F_HALF       17
`define CBS_F_IMM        18
`define CBS_F_COND       19

`define CBS_CTRL_W       20
`define CBS_RST_CTRL     20'h00000
`define CBS_RST_WORD     32'h00000000
`define CBS_RST_RES      64'h0000000000000000

`define CBS_LIM_MEM      7'h10
`define CBS_LIM_IMM      7'h0f
`define CBS_LIM_STORE    7'h08
`define CBS_HALF_SPAN    7'h10

`endif

/* File: hdl/cbs_pkg.sv */
// Types shared by the shifter design.
package cbs_pkg;

  typedef enum logic [4:0] {
    CBS_OPD_LEFT   = 5'h00,
    CBS_STORE_LO   = 5'h01,
    CBS_STORE_HI   = 5'h02,
    CBS_LEFT_SUM   = 5'h03,
    CBS_LEFT_HALF  = 5'h04,
    CBS_SUM_RIGHT  = 5'h05,
    CBS_RIGHT_HALF = 5'h06,
    CBS_ARITH_HALF = 5'h07,
    CBS_ROT_LEFT   = 5'h08,
    CBS_ROT_RIGHT  = 5'h09,
    CBS_WIDE_LEFT  = 5'h0a,
    CBS_WIDE_RIGHT = 5'h0b,
    CBS_WIDE_ARITH = 5'h0c,
    CBS_LEAD_STEP  = 5'h0d,
    CBS_CSUB_STEP  = 5'h0e,
    CBS_PROD_ALU   = 5'h0f,
    CBS_PSTORE_LO  = 5'h10,
    CBS_PSTORE_HI  = 5'h11
  } cbs_op_t;

  typedef enum logic [1:0] {
    CBS_IDLE = 2'b01,
    CBS_EXEC = 2'b10
  } cbs_state_t;

endpackage

/* File: sim/cbs_shifter_properties.sv */
// Concurrent checks on the shifter ports, bound to every shifter instance.
`timescale 1ns/1ps
`include "cbs_map.svh"

module cbs_shifter_properties
  import cbs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] i_mult_result,
  input  wire logic        i_mult_wr,
  input  wire logic        i_mult_to_sum,
  input  wire logic [31:0] o_rdata,
  input  wire logic [63:0] o_shift_out,
  input  wire logic        o_carry,
  input  wire logic        o_done
);
  // ------------------------------------------------------------
  // Operation launch decode
  // ------------------------------------------------------------
  wire logic [4:0] go_op = i_wdata[4:0];
  wire logic       go    = i_wr && i_addr == `CBS_OFS_CTRL;
  wire logic       go_ok = go && go_op <= 5'h11;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_op(logic [4:0] op);
    go && go_op == op;
  endsequence
  sequence s_store;
    go && (go_op inside {5'h01, 5'h02, 5'h10, 5'h11});
  endsequence
  sequence s_zero_cnt;
    go && (go_op inside {[5'h03:5'h07]}) && i_wdata[15:9] == 7'h00;
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_done_follows:
    assert property (go_ok |-> ##2 o_done) else $error("done missing after op");
  chk_done_cause:
    assert property (o_done |-> $past(go_ok, 2)) else $error("done without op");
  chk_out_holds:
    assert property (!o_done |-> $stable(o_shift_out)) else $error("result moved");
  chk_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("stray read data");
  chk_store_narrow:
    assert property (s_store |-> ##2 o_shift_out[63:16] == 48'h0) else $error("store wide");
  chk_store_carry:
    assert property (s_store |-> ##2 o_carry == $past(o_carry)) else $error("store carry");
  chk_zero_clears:
    assert property (s_zero_cnt |-> ##2 !o_carry) else $error("zero count carry");
  chk_rot_left:
    assert property (s_op(5'h08) |-> ##2 o_shift_out[0] == $past(o_carry))
      else $error("rotate left fill");
  chk_rot_right:
    assert property (s_op(5'h09) |-> ##2 o_shift_out[31] == $past(o_carry))
      else $error("rotate right fill");
endmodule

bind cbs_shifter cbs_shifter_properties i_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_mult_result(i_mult_result), .i_mult_wr(i_mult_wr),
  .i_mult_to_sum(i_mult_to_sum), .o_rdata(o_rdata), .o_shift_out(o_shift_out),
  .o_carry(o_carry), .o_done(o_done));

/* File: sim/tb_top.sv */
// Self-checking bench for the datapath barrel shifter.
`timescale 1ns/1ps
`include "cbs_map.svh"

module tb_top
  import cbs_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] i_mult_result = 32'h0;
  logic        i_mult_wr = 1'b0;
  logic        i_mult_to_sum = 1'b0;
  logic [31:0] o_rdata;
  logic [63:0] o_shift_out;
  logic        o_carry;
  logic        o_done;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #20 i_mclk = ~i_mclk;

  cbs_shifter i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_mult_result(i_mult_result), .i_mult_wr(i_mult_wr),
    .i_mult_to_sum(i_mult_to_sum), .o_rdata(o_rdata), .o_shift_out(o_shift_out),
    .o_carry(o_carry), .o_done(o_done));

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    chk("rdata", {32'h0, o_rdata}, {32'h0, e});
  endtask

  task automatic mw(input logic to_sum, input logic [31:0] d);
    @(posedge i_mclk);
    i_mult_result <= d;
    i_mult_to_sum <= to_sum;
    i_mult_wr     <= 1'b1;
    @(posedge i_mclk);
    i_mult_wr <= 1'b0;
  endtask

  // Flags f: cond, immediate, upper half, T(4:0), use T, sign fill.
  function automatic logic [31:0] cw(input logic [4:0] op, input logic [5:0] n,
                                     input logic [5:0] f, input logic [2:0] pm);
    return {12'h0, f[5:1], n, pm, f[0], op};
  endfunction

  task automatic op(input logic [31:0] c);
    int k;
    wr(`CBS_OFS_CTRL, c);
    for (k = 0; k < 4 && o_done !== 1'b1; k++)
      @(negedge i_mclk);
    chk("done", {63'h0, o_done}, 64'h1);
  endtask

  task automatic sc(input logic [31:0] c, input logic [31:0] s, input logic cy);
    op(c);
    chk("carry", {63'h0, o_carry}, {63'h0, cy});
    rd(`CBS_OFS_SUM, s);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_bus;
    rd(8'h20, 32'h0);
    wr(`CBS_OFS_RES_LO, 32'h1234);
    rd(`CBS_OFS_RES_LO, 32'h0);
    wr(`CBS_OFS_PROD, 32'hdeadbeef);
    rd(`CBS_OFS_PROD, 32'hdeadbeef);
  endtask

  task automatic t_load;
    wr(`CBS_OFS_OPND, 32'h8001);
    op(cw(CBS_OPD_LEFT, 6'd4, 6'h01, 3'h0));
    rd(`CBS_OFS_SUM, 32'hfff80010);
    op(cw(CBS_OPD_LEFT, 6'd4, 6'h00, 3'h0));
    rd(`CBS_OFS_SUM, 32'h00080010);
    op(cw(CBS_OPD_LEFT, 6'd16, 6'h00, 3'h0));
    rd(`CBS_OFS_SUM, 32'h80010000);
    op(cw(CBS_OPD_LEFT, 6'd16, 6'h10, 3'h0));
    rd(`CBS_OFS_SUM, 32'h40008000);
    wr(`CBS_OFS_MCAND, 32'h3);
    rd(`CBS_OFS_MCAND, 32'h3);
    op(cw(CBS_OPD_LEFT, 6'd0, 6'h02, 3'h0));
    rd(`CBS_OFS_SUM, 32'h00040008);
  endtask

  task automatic t_sum;
    wr(`CBS_OFS_SUM, 32'hc0000001);
    sc(cw(CBS_LEFT_SUM, 6'd1, 6'h00, 3'h0), 32'h80000002, 1'b1);
    wr(`CBS_OFS_MCAND, 32'h10);
    sc(cw(CBS_LEFT_SUM, 6'd0, 6'h02, 3'h0), 32'h80000002, 1'b0);
    wr(`CBS_OFS_MCAND, 32'h11);
    wr(`CBS_OFS_SUM, 32'h00008000);
    sc(cw(CBS_LEFT_SUM, 6'd0, 6'h06, 3'h0), 32'h0, 1'b1);
    wr(`CBS_OFS_SUM, 32'hc0000001);
    sc(cw(CBS_LEFT_SUM, 6'd16, 6'h01, 3'h0), 32'h00010000, 1'b0);
    wr(`CBS_OFS_SUM, 32'h80000003);
    sc(cw(CBS_SUM_RIGHT, 6'd2, 6'h01, 3'h0), 32'he0000000, 1'b1);
    wr(`CBS_OFS_SUM, 32'h80000003);
    sc(cw(CBS_SUM_RIGHT, 6'd2, 6'h00, 3'h0), 32'h20000000, 1'b1);
    sc(cw(CBS_SUM_RIGHT, 6'd0, 6'h00, 3'h0), 32'h20000000, 1'b0);
  endtask

  task automatic t_half;
    wr(`CBS_OFS_SUM, 32'h80014003);
    sc(cw(CBS_LEFT_HALF, 6'd1, 6'h08, 3'h0), 32'h00024003, 1'b1);
    sc(cw(CBS_RIGHT_HALF, 6'd1, 6'h00, 3'h0), 32'h00022001, 1'b1);
    wr(`CBS_OFS_SUM, 32'h00008003);
    sc(cw(CBS_ARITH_HALF, 6'd1, 6'h00, 3'h0), 32'h0000c001, 1'b1);
    wr(`CBS_OFS_MCAND, 32'h20);
    sc(cw(CBS_ARITH_HALF, 6'd0, 6'h02, 3'h0), 32'h0000c001, 1'b0);
  endtask

  task automatic t_rot;
    wr(`CBS_OFS_STAT, 32'h0);
    wr(`CBS_OFS_SUM, 32'h80000002);
    sc(cw(CBS_ROT_LEFT, 6'd0, 6'h00, 3'h0), 32'h00000004, 1'b1);
    rd(`CBS_OFS_STAT, 32'h1);
    sc(cw(CBS_ROT_RIGHT, 6'd0, 6'h00, 3'h0), 32'h80000002, 1'b0);
  endtask

  task automatic t_wide;
    wr(`CBS_OFS_SUM, 32'h1);
    wr(`CBS_OFS_PROD, 32'h80000000);
    op(cw(CBS_WIDE_LEFT, 6'd1, 6'h00, 3'h0));
    chk("wide_left", o_shift_out, 64'h00000003_00000000);
    rd(`CBS_OFS_PROD, 32'h0);
    wr(`CBS_OFS_SUM, 32'h80000000);
    op(cw(CBS_WIDE_ARITH, 6'd16, 6'h00, 3'h0));
    chk("wide_arith", o_shift_out, 64'hffff8000_00000000);
    rd(`CBS_OFS_RES_HI, 32'hffff8000);
    op(cw(CBS_WIDE_RIGHT, 6'd0, 6'h02, 3'h0));
    chk("wide_right", o_shift_out, 64'h00000000_ffff8000);
  endtask

  task automatic t_prod;
    logic [31:0] p;
    logic [31:0] e;
    p = 32'h80000010;
    mw(1'b0, p);
    rd(`CBS_OFS_PROD, p);
    for (int pm = 0; pm < 8; pm++) begin
      e = (pm == 0) ? p << 1 : (pm == 1) ? p : 32'($signed(p) >>> (pm - 1));
      op(cw(CBS_PROD_ALU, 6'd0, 6'h00, 3'(pm)));
      chk("prod_alu", {32'h0, o_shift_out[31:0]}, {32'h0, e});
      op(cw(CBS_PSTORE_LO, 6'd0, 6'h00, 3'(pm)));
      chk("prod_lo", o_shift_out, {48'h0, e[15:0]});
      op(cw(CBS_PSTORE_HI, 6'd0, 6'h00, 3'(pm)));
      chk("prod_hi", o_shift_out, {48'h0, e[31:16]});
    end
  endtask

  task automatic t_store;
    mw(1'b1, 32'h12345678);
    rd(`CBS_OFS_SUM, 32'h12345678);
    wr(`CBS_OFS_STAT, 32'h1);
    op(cw(CBS_STORE_LO, 6'd4, 6'h00, 3'h0));
    chk("store_lo", o_shift_out, 64'h6780);
    op(cw(CBS_STORE_HI, 6'd4, 6'h00, 3'h0));
    chk("store_hi", o_shift_out, 64'h2345);
    op(cw(CBS_STORE_HI, 6'd0, 6'h00, 3'h0));
    chk("store_hi0", o_shift_out, 64'h1234);
    chk("store_c", {63'h0, o_carry}, 64'h1);
  endtask

  task automatic t_step;
    wr(`CBS_OFS_SUM, 32'h20000000);
    op(cw(CBS_LEAD_STEP, 6'd0, 6'h20, 3'h0));
    rd(`CBS_OFS_SUM, 32'h40000000);
    op(cw(CBS_LEAD_STEP, 6'd0, 6'h20, 3'h0));
    rd(`CBS_OFS_SUM, 32'h40000000);
    wr(`CBS_OFS_SUM, 32'h00010000);
    wr(`CBS_OFS_OPND, 32'h1);
    op(cw(CBS_CSUB_STEP, 6'd0, 6'h00, 3'h0));
    rd(`CBS_OFS_SUM, 32'h00010001);
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_bus();
    t_load();
    t_sum();
    t_half();
    t_rot();
    t_wide();
    t_prod();
    t_store();
    t_step();
    complete_run();
  end
endmodule
